// *** rtl/bkrcsm_pkg.sv ***
// Summary of operation
// (R01) A breaker with its function disabled issues no control action at all.
// (R02) Panel open/close requests count only while panel button control is enabled.
// (R03) Each breaker holds a six-character label for displayed messages.
// (R04) Three-pole mode commands all poles; one-pole mode allows per-pole or all; the code has one open and one close command for all poles in both modes.
// (R05) Open command is asserted while the selected open operand is true.
// (R06) Close command is asserted while the selected close operand is true; the code holds it low while the open command is asserted.
// (R07) Position inputs read 0 whenever the tracked pole is open.
// (R08) Three-pole mode takes the whole breaker state from phase A alone.
// (R09) One-pole mode tracks A, B and C from their own inputs.
// (R10) Three-pole mode ignores the phase B and C position inputs.
// (R11) The external alarm input is sampled and made visible to breaker logic.
// (R12) No pole disagreement while poles differ for less than the alarm delay.
// (R13) Two independent breakers; a single-breaker use must use breaker one.
// (R14) Disagreement flag rises after full delay and clears when poles agree.
// (R15) A panel selection deselects itself after a timeout, only with panel control.
package bkrcsm_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [7:0] BKRCSM_CTRL0_OFS = 8'h00;
  localparam logic [7:0] BKRCSM_DLY0_OFS = 8'h04;
  localparam logic [7:0] BKRCSM_SBO0_OFS = 8'h08;
  localparam logic [7:0] BKRCSM_LBLL0_OFS = 8'h0C;
  localparam logic [7:0] BKRCSM_LBLH0_OFS = 8'h10;
  localparam logic [7:0] BKRCSM_STAT0_OFS = 8'h14;
  localparam logic [7:0] BKRCSM_BANK_STRIDE = 8'h20;
  localparam logic [7:0] BKRCSM_WORD_MASK = 8'h1C;
  localparam logic [7:0] BKRCSM_BANK_MASK = 8'hE0;

  // Control bit positions
  localparam int BKRCSM_CTRL_FUNC_EN = 0;
  localparam int BKRCSM_CTRL_PANEL_EN = 1;
  localparam int BKRCSM_CTRL_ONE_POLE = 2;

  localparam logic [31:0] BKRCSM_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] BKRCSM_DLY_RST = 32'h0000_0032;
  localparam logic [31:0] BKRCSM_SBO_RST = 32'h0000_0032;
  localparam logic [31:0] BKRCSM_LBL_RST = 32'h0000_0000;
  localparam logic [31:0] BKRCSM_ZERO = 32'h0000_0000;

  // One millisecond tick at 50 MHz
  localparam int BKRCSM_CLK_HZ = 50_000_000;
  localparam int BKRCSM_TICK_US = 1000;
  localparam int BKRCSM_TICK_CYC = BKRCSM_CLK_HZ / 1_000_000 * BKRCSM_TICK_US;

  localparam logic [1:0] BKRCSM_RESP_OKAY = 2'b00;
  localparam logic [1:0] BKRCSM_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic open_op;
    logic close_op;
    logic pos_a;
    logic pos_b;
    logic pos_c;
    logic alarm;
    logic btn_sel;
    logic btn_open;
    logic btn_close;
  } bkrcsm_in_t;

  typedef struct packed {
    logic open_cmd;
    logic close_cmd;
    logic closed_a;
    logic closed_b;
    logic closed_c;
    logic disagree;
    logic alarm;
    logic selected;
  } bkrcsm_out_t;

  typedef struct packed {
    logic func_en;
    logic panel_en;
    logic one_pole;
    logic [15:0] alarm_dly_ms;
    logic [15:0] sbo_ms;
  } bkrcsm_cfg_t;

  typedef enum logic [2:0] {
    BKRCSM_SEL_IDLE = 3'b001,
    BKRCSM_SEL_ARMED = 3'b010,
    BKRCSM_SEL_HOLD = 3'b100
  } bkrcsm_sel_t;

endpackage

// *** rtl/bkrcsm_breaker.sv ***
`timescale 1ns/10ps
module bkrcsm_breaker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire bkrcsm_pkg::bkrcsm_cfg_t cfg,
  input wire bkrcsm_pkg::bkrcsm_in_t in_s,
  output bkrcsm_pkg::bkrcsm_out_t out_r
);
  import bkrcsm_pkg::*;

  logic [15:0] dis_cnt_r;
  logic [15:0] sbo_cnt_r;
  bkrcsm_sel_t sel_r;
  bkrcsm_sel_t sel_nxt;
  bkrcsm_out_t out_nxt;

  // ==========================================================
  // Pole position
  // ==========================================================
  wire pb_eff = cfg.one_pole ? in_s.pos_b : in_s.pos_a; // [R08] [R09] [R10]
  wire pc_eff = cfg.one_pole ? in_s.pos_c : in_s.pos_a; // [R10]
  wire poles_differ = cfg.one_pole &&
    !((in_s.pos_a == in_s.pos_b) && (in_s.pos_a == in_s.pos_c));
  wire dly_done = (dis_cnt_r >= cfg.alarm_dly_ms); // [R12]

  // ==========================================================
  // Select-before-operate
  // ==========================================================
  wire sbo_gate = cfg.func_en && cfg.panel_en; // [R02] [R15]
  wire sbo_expired = (sbo_cnt_r >= cfg.sbo_ms);
  wire is_sel = (sel_r == BKRCSM_SEL_ARMED);
  wire btn_open_ok = is_sel && in_s.btn_open;
  wire btn_close_ok = is_sel && in_s.btn_close;

  always_comb begin
    sel_nxt = sel_r;
    case (sel_r)
      BKRCSM_SEL_IDLE: if (sbo_gate && in_s.btn_sel) sel_nxt = BKRCSM_SEL_ARMED;
      BKRCSM_SEL_ARMED: begin
        if (!sbo_gate || sbo_expired) begin
          sel_nxt = BKRCSM_SEL_HOLD; // [R15]
        end
      end
      // Wait for select release so a held button cannot reselect
      BKRCSM_SEL_HOLD: if (!in_s.btn_sel) sel_nxt = BKRCSM_SEL_IDLE;
      default: sel_nxt = BKRCSM_SEL_IDLE;
    endcase
  end

  always_comb begin
    out_nxt = '0;
    out_nxt.open_cmd = cfg.func_en && (in_s.open_op || btn_open_ok); // [R01] [R05]
    out_nxt.close_cmd = cfg.func_en && !out_nxt.open_cmd &&
      (in_s.close_op || btn_close_ok); // [R01] [R06] [R04]
    out_nxt.closed_a = in_s.pos_a; // [R07]
    out_nxt.closed_b = pb_eff;
    out_nxt.closed_c = pc_eff;
    out_nxt.disagree = cfg.func_en && poles_differ && dly_done; // [R14]
    out_nxt.alarm = in_s.alarm; // [R11]
    out_nxt.selected = (sel_nxt == BKRCSM_SEL_ARMED);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dis_cnt_r <= '0;
      sbo_cnt_r <= '0;
      sel_r <= BKRCSM_SEL_IDLE;
      out_r <= '0;
    end else begin
      sel_r <= sel_nxt;
      out_r <= out_nxt;
      if (!poles_differ) dis_cnt_r <= '0; // [R14]
      else if (tick && !dly_done) dis_cnt_r <= dis_cnt_r + 16'h0001;
      if (!is_sel) sbo_cnt_r <= '0;
      else if (tick && !sbo_expired) sbo_cnt_r <= sbo_cnt_r + 16'h0001;
    end
  end

  dis_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !poles_differ |=> !out_r.disagree) // [R14]
    else $error("disagree not cleared");
  dis_early_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (out_r.disagree && cfg.alarm_dly_ms != 16'h0000) |->
    $past(dis_cnt_r) >= cfg.alarm_dly_ms) // [R12]
    else $error("disagree before delay");
  func_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg.func_en |=> !out_r.open_cmd && !out_r.close_cmd) // [R01]
    else $error("command while disabled");
  open_cmd_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg.func_en && in_s.open_op) |=> out_r.open_cmd) // [R05]
    else $error("open not asserted");
  close_cmd_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (cfg.func_en && in_s.close_op && !in_s.open_op && !btn_open_ok)
    |=> out_r.close_cmd) // [R06]
    else $error("close not asserted");
  three_pole_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg.one_pole |=> out_r.closed_b == out_r.closed_a &&
    out_r.closed_c == out_r.closed_a && !out_r.disagree) // [R08] [R10]
    else $error("three-pole uses B or C");
  one_pole_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg.one_pole |=> out_r.closed_b == $past(in_s.pos_b) &&
    out_r.closed_c == $past(in_s.pos_c)) // [R09]
    else $error("one-pole tracking wrong");
  panel_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg.panel_en |=> !out_r.selected) // [R02]
    else $error("select without panel control");
  alarm_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> out_r.alarm == $past(in_s.alarm)) // [R11]
    else $error("alarm not passed");

endmodule

// *** rtl/bkrcsm_top.sv ***
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module bkrcsm_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire bkrcsm_pkg::bkrcsm_in_t bkr1_in,
  input wire bkrcsm_pkg::bkrcsm_in_t bkr2_in,
  output bkrcsm_pkg::bkrcsm_out_t bkr1_out,
  output bkrcsm_pkg::bkrcsm_out_t bkr2_out
);
  import bkrcsm_pkg::*;

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  bkrcsm_in_t [1:0] meta_r;
  bkrcsm_in_t [1:0] sync_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= {bkr2_in, bkr1_in};
      sync_r <= meta_r;
    end
  end

  // ==========================================================
  // Millisecond tick
  // ==========================================================
  logic [15:0] tick_cnt_r;
  logic tick_r;
  wire tick_wrap = (tick_cnt_r == 16'(BKRCSM_TICK_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_wrap ? 16'h0000 : tick_cnt_r + 16'h0001;
      tick_r <= tick_wrap;
    end
  end

  // ==========================================================
  // Registers, one bank per breaker
  // ==========================================================
  logic [31:0] ctrl_r [2];
  logic [31:0] dly_r [2];
  logic [31:0] sbo_r [2];
  logic [31:0] lbll_r [2];
  logic [31:0] lblh_r [2];
  bkrcsm_cfg_t cfg [2];
  bkrcsm_out_t bout [2];

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction

  // Bank index 0 or 1; anything above is unmapped
  function automatic logic addr_ok(input logic [7:0] a);
    logic [7:0] w;
    w = a & BKRCSM_WORD_MASK;
    return ((a & BKRCSM_BANK_MASK) <= BKRCSM_BANK_STRIDE) &&
      (w <= BKRCSM_STAT0_OFS) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic addr_bank(input logic [7:0] a);
    return (a & BKRCSM_BANK_MASK) == BKRCSM_BANK_STRIDE;
  endfunction

  // ==========================================================
  // AXI4-Lite write
  // ==========================================================
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held_r || aw_take;
  wire w_have = w_held_r || w_take;
  wire [7:0] wa = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wd = w_held_r ? wdata_r : s_axi_wdata;
  wire [3:0] ws = w_held_r ? wstrb_r : s_axi_wstrb;
  wire wr_fire = aw_have && w_have && !s_axi_bvalid;
  wire wr_ok = addr_ok(wa) && ((wa & BKRCSM_WORD_MASK) != BKRCSM_STAT0_OFS);
  wire wr_bank = addr_bank(wa);
  wire [7:0] wr_word = wa & BKRCSM_WORD_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= BKRCSM_RESP_OKAY;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      s_axi_awready <= !aw_have && !s_axi_bvalid && !wr_fire;
      s_axi_wready <= !w_have && !s_axi_bvalid && !wr_fire;
      if (aw_take) awaddr_r <= s_axi_awaddr;
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? BKRCSM_RESP_OKAY : BKRCSM_RESP_SLVERR;
      end else begin
        aw_held_r <= aw_have;
        w_held_r <= w_have;
        if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int b = 0; b < 2; b++) begin
        ctrl_r[b] <= BKRCSM_CTRL_RST;
        dly_r[b] <= BKRCSM_DLY_RST;
        sbo_r[b] <= BKRCSM_SBO_RST;
        lbll_r[b] <= BKRCSM_LBL_RST;
        lblh_r[b] <= BKRCSM_LBL_RST;
      end
    end else if (wr_fire && wr_ok) begin
      case (wr_word)
        BKRCSM_CTRL0_OFS: ctrl_r[wr_bank] <= merge(ctrl_r[wr_bank], wd, ws);
        BKRCSM_DLY0_OFS: dly_r[wr_bank] <= merge(dly_r[wr_bank], wd, ws);
        BKRCSM_SBO0_OFS: sbo_r[wr_bank] <= merge(sbo_r[wr_bank], wd, ws);
        // Label: six characters, four in the low word, two in the high
        BKRCSM_LBLL0_OFS: lbll_r[wr_bank] <= merge(lbll_r[wr_bank], wd, ws); // [R03]
        BKRCSM_LBLH0_OFS: lblh_r[wr_bank] <= merge(lblh_r[wr_bank], wd,
                                                  ws & 4'b0011); // [R03]
        default: ;
      endcase
    end
  end

  // ==========================================================
  // AXI4-Lite read
  // ==========================================================
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rd_bank = addr_bank(s_axi_araddr);
  wire [7:0] rd_word = s_axi_araddr & BKRCSM_WORD_MASK;
  logic [31:0] rd_val;

  always_comb begin
    rd_val = BKRCSM_ZERO;
    case (rd_word)
      BKRCSM_CTRL0_OFS: rd_val = ctrl_r[rd_bank] & 32'h0000_0007;
      BKRCSM_DLY0_OFS: rd_val = dly_r[rd_bank] & 32'h0000_FFFF;
      BKRCSM_SBO0_OFS: rd_val = sbo_r[rd_bank] & 32'h0000_FFFF;
      BKRCSM_LBLL0_OFS: rd_val = lbll_r[rd_bank];
      BKRCSM_LBLH0_OFS: rd_val = lblh_r[rd_bank];
      BKRCSM_STAT0_OFS: rd_val = {24'h00_0000, bout[rd_bank]};
      default: rd_val = BKRCSM_ZERO;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= BKRCSM_ZERO;
      s_axi_rresp <= BKRCSM_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= addr_ok(s_axi_araddr) ? rd_val : BKRCSM_ZERO;
        s_axi_rresp <= addr_ok(s_axi_araddr) ? BKRCSM_RESP_OKAY
                                              : BKRCSM_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Two independent breakers; bank 0 is breaker one
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_bkr
      assign cfg[g].func_en = ctrl_r[g][BKRCSM_CTRL_FUNC_EN]; // [R01]
      assign cfg[g].panel_en = ctrl_r[g][BKRCSM_CTRL_PANEL_EN]; // [R02]
      assign cfg[g].one_pole = ctrl_r[g][BKRCSM_CTRL_ONE_POLE]; // [R04]
      assign cfg[g].alarm_dly_ms = dly_r[g][15:0];
      assign cfg[g].sbo_ms = sbo_r[g][15:0];
      bkrcsm_breaker u_bkr (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick_r),
        .cfg(cfg[g]),
        .in_s(sync_r[g]),
        .out_r(bout[g])
      ); // [R13]
    end
  endgenerate

  assign bkr1_out = bout[0];
  assign bkr2_out = bout[1];

  bank_split_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ctrl_r[1][BKRCSM_CTRL_FUNC_EN]) |=> !bkr2_out.open_cmd) // [R13]
    else $error("breaker two acted while disabled");
  label_hi_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lblh_r[0][31:16] == 16'h0000 && lblh_r[1][31:16] == 16'h0000) // [R03]
    else $error("label longer than six characters");

endmodule

// *** verif/bkrcsm_pole_model.sv ***
`timescale 1ns/10ps
// ==========================================================
// Breaker poles driven by the output relays
// ==========================================================
module bkrcsm_pole_model #(
  parameter int STROKE = 3
) (
  input wire logic aclk,
  input wire logic open_cmd,
  input wire logic close_cmd,
  input wire logic stuck_c,
  output logic pos_a,
  output logic pos_b,
  output logic pos_c
);
  int cnt = 0;
  initial begin
    pos_a = 1'b1;
    pos_b = 1'b1;
    pos_c = 1'b1;
  end
  // Pole C lags a cycle: real poles never move in step
  always @(posedge aclk) begin
    cnt <= (open_cmd || close_cmd) ? cnt + 1 : 0;
    if (cnt >= STROKE) begin
      pos_a <= close_cmd && !open_cmd;
      pos_b <= close_cmd && !open_cmd;
    end
    if (cnt > STROKE && !stuck_c) begin
      pos_c <= close_cmd && !open_cmd;
    end
  end
endmodule

// *** verif/test_breaker_control_status_monitor.sv ***
`timescale 1ns/10ps
module test_breaker_control_status_monitor;
  import bkrcsm_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  bkrcsm_in_t drv [2];
  bkrcsm_in_t bi [2];
  bkrcsm_out_t bo [2];
  logic stuck_c = 1'b0;
  logic pa;
  logic pb;
  logic pc;
  logic [31:0] d1;
  logic [31:0] d2;
  int ctrl_m [2];
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;

  // ==========================================================
  // Clock, watchdog, stimulus assembly
  // ==========================================================
  initial begin
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      fail_count++;
      $display("BAD %0t watchdog expired", $time);
      end_of_test();
    end
  end
  always_comb begin
    bi = drv;
    bi[0].pos_a = pa;
    bi[0].pos_b = pb;
    bi[0].pos_c = pc;
  end

  bkrcsm_pole_model i_poles (.aclk(aclk), .open_cmd(bo[0].open_cmd),
    .close_cmd(bo[0].close_cmd), .stuck_c(stuck_c), .pos_a(pa),
    .pos_b(pb), .pos_c(pc));

  bkrcsm_top i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bkr1_in(bi[0]),
    .bkr2_in(bi[1]), .bkr1_out(bo[0]), .bkr2_out(bo[1]));

  // ==========================================================
  // Checking and bus tasks
  // ==========================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awready === 1'b1 && !aw_ok) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er), "bresp");
    if (er == BKRCSM_RESP_OKAY && a[4:0] == 5'h00) ctrl_m[a[5]] = d;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b0;
    chk(rdata, ed, "rdata");
    chk(32'(rresp), 32'(er), "rresp");
  endtask

  function automatic logic [7:0] model(int b, logic dis, logic sel);
    bkrcsm_in_t i;
    bkrcsm_out_t o;
    logic f;
    logic one;
    i = bi[b];
    f = ctrl_m[b][0];
    one = ctrl_m[b][2];
    o.open_cmd = f & (i.open_op | (sel & ctrl_m[b][1] & i.btn_open));
    // Open wins so both relays never pull in together
    o.close_cmd = f & (i.close_op | (sel & ctrl_m[b][1] & i.btn_close)) &
      ~o.open_cmd;
    o.closed_a = i.pos_a;
    o.closed_b = one ? i.pos_b : i.pos_a;
    o.closed_c = one ? i.pos_c : i.pos_a;
    o.disagree = dis;
    o.alarm = i.alarm;
    o.selected = sel;
    return o;
  endfunction

  task automatic chk_bkr(input int b, input logic dis, input logic sel,
                         input string m);
    repeat (16) @(posedge aclk);
    chk(32'(bo[b]), 32'(model(b, dis, sel)), m);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    drv[0] = '0;
    drv[1] = '0;
    void'($urandom(74260));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int b = 0; b < 2; b++) begin
      rd(8'(b * 32) + BKRCSM_CTRL0_OFS, BKRCSM_CTRL_RST, 2'b00);
      rd(8'(b * 32) + BKRCSM_DLY0_OFS, BKRCSM_DLY_RST, 2'b00);
      rd(8'(b * 32) + BKRCSM_SBO0_OFS, BKRCSM_SBO_RST, 2'b00);
      rd(8'(b * 32) + BKRCSM_LBLH0_OFS, BKRCSM_LBL_RST, 2'b00);
    end
    d1 = $urandom();
    d2 = $urandom();
    wr(BKRCSM_LBLL0_OFS, d1, BKRCSM_RESP_OKAY);
    wr(BKRCSM_LBLH0_OFS, d2, BKRCSM_RESP_OKAY);
    rd(BKRCSM_LBLL0_OFS, d1, BKRCSM_RESP_OKAY);
    rd(BKRCSM_LBLH0_OFS, {16'h0000, d2[15:0]}, BKRCSM_RESP_OKAY);
    // Only byte one may change: the strobes pick single characters
    wstrb <= 4'h2;
    wr(BKRCSM_LBLL0_OFS, d2, BKRCSM_RESP_OKAY);
    wstrb <= 4'hF;
    rd(BKRCSM_LBLL0_OFS, {d1[31:16], d2[15:8], d1[7:0]},
       BKRCSM_RESP_OKAY);
    wr(BKRCSM_STAT0_OFS, d1, BKRCSM_RESP_SLVERR);
    rd(8'h18, BKRCSM_ZERO, BKRCSM_RESP_SLVERR);
    rd(8'h02, BKRCSM_ZERO, BKRCSM_RESP_SLVERR);
    $display("test registers done");

    drv[1].open_op <= 1'b1;
    chk_bkr(1, 1'b0, 1'b0, "disabled");
    wr(8'h20, 32'h0000_0001, BKRCSM_RESP_OKAY);
    chk_bkr(1, 1'b0, 1'b0, "open");
    chk_bkr(0, 1'b0, 1'b0, "other breaker");
    drv[1].open_op <= 1'b0;
    drv[1].close_op <= 1'b1;
    drv[1].alarm <= 1'b1;
    chk_bkr(1, 1'b0, 1'b0, "close");
    for (int i = 0; i < 4; i++) begin
      drv[1].pos_a <= 1'($urandom());
      drv[1].pos_b <= 1'($urandom());
      drv[1].pos_c <= 1'($urandom());
      chk_bkr(1, 1'b0, 1'b0, "three pole");
    end
    $display("test operands done");

    wr(BKRCSM_DLY0_OFS, 32'h0000_0002, BKRCSM_RESP_OKAY);
    wr(BKRCSM_CTRL0_OFS, 32'h0000_0005, BKRCSM_RESP_OKAY);
    stuck_c <= 1'b1;
    drv[0].open_op <= 1'b1;
    repeat (2000) @(posedge aclk);
    chk_bkr(0, 1'b0, 1'b0, "pole lag");
    wr(BKRCSM_DLY0_OFS, 32'h0000_0001, BKRCSM_RESP_OKAY);
    wr(BKRCSM_BANK_STRIDE + BKRCSM_SBO0_OFS, 32'h0000_0001,
       BKRCSM_RESP_OKAY);
    wr(BKRCSM_BANK_STRIDE + BKRCSM_CTRL0_OFS, 32'h0000_0003,
       BKRCSM_RESP_OKAY);
    drv[1].btn_sel <= 1'b1;
    chk_bkr(1, 1'b0, 1'b1, "armed two");
    // The first millisecond tick ends both the delay and the selection
    for (int n = 0; n < 60000 && bo[0].disagree !== 1'b1; n++) begin
      @(posedge aclk);
    end
    chk(32'(bo[0].disagree), 32'h0000_0001, "delay");
    chk_bkr(1, 1'b0, 1'b0, "timeout");
    wr(BKRCSM_DLY0_OFS, 32'h0000_0000, BKRCSM_RESP_OKAY);
    chk_bkr(0, 1'b1, 1'b0, "disagree");
    stuck_c <= 1'b0;
    chk_bkr(0, 1'b0, 1'b0, "agree");
    $display("test poles done");

    drv[0].open_op <= 1'b0;
    wr(BKRCSM_CTRL0_OFS, 32'h0000_0001, BKRCSM_RESP_OKAY);
    drv[0].btn_sel <= 1'b1;
    chk_bkr(0, 1'b0, 1'b0, "panel off");
    drv[0].btn_sel <= 1'b0;
    wr(BKRCSM_CTRL0_OFS, 32'h0000_0003, BKRCSM_RESP_OKAY);
    drv[0].btn_sel <= 1'b1;
    chk_bkr(0, 1'b0, 1'b1, "armed");
    drv[0].btn_sel <= 1'b0;
    drv[0].btn_open <= 1'b1;
    chk_bkr(0, 1'b0, 1'b1, "panel open");
    drv[0].btn_open <= 1'b0;
    drv[0].btn_close <= 1'b1;
    chk_bkr(0, 1'b0, 1'b1, "panel close");
    wr(BKRCSM_CTRL0_OFS, 32'h0000_0001, BKRCSM_RESP_OKAY);
    chk_bkr(0, 1'b0, 1'b0, "deselect");
    $display("test panel done");
    end_of_test();
  end
endmodule
